// *** pkg/memmap_pkg.sv ***
/*
 holds the address map constants and request/answer structs for the
 program and data memory decoder. assumes an 8-bit byte-wide core bus.
*/
package memmap_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // flash sizes selectable per variant: last implemented address
  typedef enum logic [2:0] {
    SIZE_16K = 3'h0,
    SIZE_24K = 3'h1,
    SIZE_32K = 3'h3,
    SIZE_48K = 3'h2,
    SIZE_64K = 3'h6
  } flash_size_t;

  localparam logic [15:0] FLASH_END_16K = 16'h3FFF;
  localparam logic [15:0] FLASH_END_24K = 16'h5FFF;
  localparam logic [15:0] FLASH_END_32K = 16'h7FFF;
  localparam logic [15:0] FLASH_END_48K = 16'hBFFF;
  localparam logic [15:0] FLASH_END_64K = 16'hFFFF;

  // reserved low program slots, two bytes each
  localparam logic [15:0] OPTION_ADDR = 16'h0000;
  localparam logic [15:0] RESET_VEC_ADDR = 16'h0002;
  localparam logic [15:0] WDT_VEC_ADDR = 16'h0004;
  localparam logic [15:0] TRAP_VEC_ADDR = 16'h0006;
  localparam logic [15:0] IRQ_VEC_FIRST = 16'h0008;
  localparam logic [15:0] IRQ_VEC_LAST = 16'h0037;
  localparam logic [15:0] CODE_START = 16'h0038;

  // data space layout
  localparam logic [15:0] ROM_BASE = 16'hFF80;
  localparam logic [15:0] PART_FIRST = 16'hFFC0;
  localparam logic [15:0] PART_LAST = 16'hFFD3;
  localparam int PART_LEN = 20;

  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  typedef enum logic [2:0] {
    REG_OPTION = 3'h0,
    REG_RESET = 3'h1,
    REG_WDT = 3'h3,
    REG_TRAP = 3'h2,
    REG_IRQ = 3'h6,
    REG_CODE = 3'h7
  } prog_region_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } mem_rsp_t;
endpackage : memmap_pkg

// *** rtl/part_id_rom.sv ***
/*
 holds the part identification string as a registered lookup table.
 assumes the caller presents an index below the string length.
*/
`timescale 1ns/1ps
module part_id_rom
  import memmap_pkg::*;
#(
  // arbitrary neutral identification text, padded with zeros
  parameter logic [8*PART_LEN-1:0] PART_TEXT =
    {8'h50, 8'h41, 8'h52, 8'h54, 8'h2D, 8'h30, 8'h30, 8'h31,
     8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
     8'h00, 8'h00, 8'h00, 8'h00}
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // lookup
  input wire logic [4:0] index,
  output logic [7:0] data
);
  logic [7:0] data_reg;
  logic [7:0] data_next;

  // left justified: index 0 is the first character in the top byte
  always_comb begin
    data_next = PAD_BYTE;
    if (int'(index) < PART_LEN) begin
      data_next = PART_TEXT[8*(PART_LEN-1-int'(index)) +: 8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_reg <= PAD_BYTE;
    end else begin
      data_reg <= data_next;
    end
  end

  assign data = data_reg;
endmodule : part_id_rom

// *** rtl/program_data_memory_map.sv ***
/*
 decodes program and data space accesses from the core: flash window,
 vector regions, blank reads, and the read-only identification block.
 assumes a flash macro that answers within the select cycle, and that
 the core issues data space accesses only from its external load ops.
*/
`timescale 1ns/1ps
module program_data_memory_map
  import memmap_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // variant strap
  input wire flash_size_t flash_size,
  // program space from core
  input wire mem_req_t prog_req,
  output mem_rsp_t prog_rsp,
  output prog_region_t prog_region,
  // flash macro
  output logic flash_sel,
  output logic flash_we,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_wdata,
  input wire logic [DATA_W-1:0] flash_rdata,
  // data space from core external loads
  input wire mem_req_t data_req,
  output mem_rsp_t data_rsp
);
  logic [15:0] flash_end;
  logic in_flash;
  logic prog_rd_flash_reg, prog_rd_flash_next;
  logic prog_rd_blank_reg, prog_rd_blank_next;
  logic flash_sel_reg, flash_sel_next;
  logic flash_we_reg, flash_we_next;
  logic [15:0] flash_addr_reg, flash_addr_next;
  logic [7:0] flash_wdata_reg, flash_wdata_next;
  prog_region_t region_reg, region_next;
  logic prog_valid_reg, prog_valid_next;
  logic [7:0] prog_data_reg, prog_data_next;

  logic data_part, data_rd;
  logic [4:0] part_index;
  logic [7:0] part_byte;
  logic data_sel_part_reg, data_sel_part_next;
  logic data_pend_reg, data_pend_next;
  logic data_valid_reg, data_valid_next;
  logic [7:0] data_data_reg, data_data_next;

  // variant decides the last flash address
  always_comb begin
    unique case (flash_size)
      SIZE_16K: flash_end = FLASH_END_16K;
      SIZE_24K: flash_end = FLASH_END_24K;
      SIZE_32K: flash_end = FLASH_END_32K;
      SIZE_48K: flash_end = FLASH_END_48K;
      SIZE_64K: flash_end = FLASH_END_64K;
      default: flash_end = FLASH_END_16K;
    endcase
  end

  assign in_flash = prog_req.addr <= flash_end;

  // program request stage: drive flash, classify region
  always_comb begin
    prog_rd_flash_next = prog_req.valid && !prog_req.write && in_flash;
    prog_rd_blank_next = prog_req.valid && !prog_req.write && !in_flash;
    flash_sel_next = prog_req.valid && in_flash;
    // no flash behind the address: write never reaches the macro
    flash_we_next = prog_req.valid && prog_req.write && in_flash;
    flash_addr_next = prog_req.valid ? prog_req.addr : flash_addr_reg;
    flash_wdata_next = prog_req.valid ? prog_req.wdata : flash_wdata_reg;
    region_next = region_reg;
    if (prog_req.valid) begin
      if (prog_req.addr >= CODE_START) begin
        region_next = REG_CODE;
      end else if (prog_req.addr >= IRQ_VEC_FIRST) begin
        region_next = REG_IRQ;
      end else if (prog_req.addr >= TRAP_VEC_ADDR) begin
        region_next = REG_TRAP;
      end else if (prog_req.addr >= WDT_VEC_ADDR) begin
        region_next = REG_WDT;
      end else if (prog_req.addr >= RESET_VEC_ADDR) begin
        region_next = REG_RESET;
      end else begin
        region_next = REG_OPTION;
      end
    end
  end

  // program answer stage: flash data lands one cycle after select
  always_comb begin
    prog_valid_next = prog_rd_flash_reg || prog_rd_blank_reg;
    prog_data_next = prog_data_reg;
    if (prog_rd_blank_reg) begin
      prog_data_next = BLANK_BYTE;
    end else if (prog_rd_flash_reg) begin
      prog_data_next = flash_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prog_rd_flash_reg <= 1'b0;
      prog_rd_blank_reg <= 1'b0;
      flash_sel_reg <= 1'b0;
      flash_we_reg <= 1'b0;
      flash_addr_reg <= OPTION_ADDR;
      flash_wdata_reg <= BLANK_BYTE;
      region_reg <= REG_OPTION;
      prog_valid_reg <= 1'b0;
      prog_data_reg <= BLANK_BYTE;
    end else begin
      prog_rd_flash_reg <= prog_rd_flash_next;
      prog_rd_blank_reg <= prog_rd_blank_next;
      flash_sel_reg <= flash_sel_next;
      flash_we_reg <= flash_we_next;
      flash_addr_reg <= flash_addr_next;
      flash_wdata_reg <= flash_wdata_next;
      region_reg <= region_next;
      prog_valid_reg <= prog_valid_next;
      prog_data_reg <= prog_data_next;
    end
  end

  // data space: only loads get an answer, the core never writes here
  assign data_rd = data_req.valid && !data_req.write;
  assign data_part = data_req.addr >= PART_FIRST &&
                     data_req.addr <= PART_LAST;
  assign part_index = 5'(data_req.addr - PART_FIRST);

  part_id_rom u_part_id_rom (
    .core_clk(core_clk),
    .rst(rst),
    .index(part_index),
    .data(part_byte)
  );

  // rom read is registered, so the answer is two cycles after the load
  always_comb begin
    data_pend_next = data_rd;
    data_sel_part_next = data_rd && data_part;
    data_valid_next = data_pend_reg;
    data_data_next = data_data_reg;
    if (data_pend_reg) begin
      // rest of the top block and all lower space read as fixed zero
      data_data_next = data_sel_part_reg ? part_byte : RSVD_BYTE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_pend_reg <= 1'b0;
      data_sel_part_reg <= 1'b0;
      data_valid_reg <= 1'b0;
      data_data_reg <= RSVD_BYTE;
    end else begin
      data_pend_reg <= data_pend_next;
      data_sel_part_reg <= data_sel_part_next;
      data_valid_reg <= data_valid_next;
      data_data_reg <= data_data_next;
    end
  end

  assign flash_sel = flash_sel_reg;
  assign flash_we = flash_we_reg;
  assign flash_addr = flash_addr_reg;
  assign flash_wdata = flash_wdata_reg;
  assign prog_region = region_reg;
  assign prog_rsp = '{valid: prog_valid_reg, rdata: prog_data_reg};
  assign data_rsp = '{valid: data_valid_reg, rdata: data_data_reg};
endmodule : program_data_memory_map

// *** tb/memmap_properties.sv ***
/* port checker for the memory map decoder.
   assumes it is bound to every decoder instance. */
`timescale 1ns/1ps
module memmap_properties
  import memmap_pkg::*;
(
  // decoder ports
  input wire logic core_clk,
  input wire logic rst,
  input wire flash_size_t flash_size,
  input wire mem_req_t prog_req,
  input wire mem_rsp_t prog_rsp,
  input wire prog_region_t prog_region,
  input wire logic flash_sel,
  input wire logic flash_we,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_wdata,
  input wire logic [DATA_W-1:0] flash_rdata,
  input wire mem_req_t data_req,
  input wire mem_rsp_t data_rsp
);
  logic [15:0] fend;
  logic pin;
  logic prd;
  logic dr;
  always_comb begin
    case (flash_size)
      SIZE_24K: fend = 16'h5FFF;
      SIZE_32K: fend = 16'h7FFF;
      SIZE_48K: fend = 16'hBFFF;
      SIZE_64K: fend = 16'hFFFF;
      default: fend = 16'h3FFF;
    endcase
    pin = prog_req.valid && prog_req.addr <= fend;
    prd = prog_req.valid && !prog_req.write;
    dr = data_req.valid && !data_req.write;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_sel_inside: assert property (pin |=> flash_sel
    && flash_addr == $past(prog_req.addr)) else $error("no flash select");
  chk_blank_quiet: assert property (prog_req.valid && !pin |=>
    !flash_sel && !flash_we) else $error("blank access reached flash");
  chk_write_pass: assert property (pin && prog_req.write |=> flash_we
    && flash_wdata == $past(prog_req.wdata)) else $error("write lost");
  chk_blank_read: assert property (prd && !pin |-> ##2 prog_rsp.valid
    && prog_rsp.rdata == BLANK_BYTE) else $error("blank read not FF");
  chk_read_data: assert property (prd && pin |-> ##2 prog_rsp.valid
    && prog_rsp.rdata == $past(flash_rdata)) else $error("bad read data");
  chk_code_region: assert property (prog_req.valid
    && prog_req.addr >= 16'h0038 |=> prog_region == REG_CODE)
    else $error("code region wrong");
  chk_rsvd_zero: assert property (dr && (data_req.addr < 16'hFFC0
    || data_req.addr > 16'hFFD3) |-> ##2 data_rsp.valid
    && data_rsp.rdata == RSVD_BYTE) else $error("reserved read wrong");
  chk_data_cause: assert property (data_rsp.valid |-> $past(dr, 2))
    else $error("data answer without read");
  cov_blank: cover property (prd && !pin);
  cov_write: cover property (pin && prog_req.write);
  cov_data: cover property (dr);
endmodule : memmap_properties

bind program_data_memory_map memmap_properties chk (
  .core_clk(core_clk),
  .rst(rst),
  .flash_size(flash_size),
  .prog_req(prog_req),
  .prog_rsp(prog_rsp),
  .prog_region(prog_region),
  .flash_sel(flash_sel),
  .flash_we(flash_we),
  .flash_addr(flash_addr),
  .flash_wdata(flash_wdata),
  .flash_rdata(flash_rdata),
  .data_req(data_req),
  .data_rsp(data_rsp)
);

// *** tb/flash_model.sv ***
/* behavioural flash macro: reads follow the registered address at once.
   assumes the decoder holds the address after a select. */
`timescale 1ns/1ps
module flash_model
  import memmap_pkg::*;
(
  // decoder side
  input wire logic core_clk,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  // unwritten cells hold a pattern, which reads FF only where the two address bytes XOR to A5
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = 8'(i[7:0] ^ i[15:8]) ^ 8'h5A;
    end
  end
  assign rdata = mem[addr];
  always @(posedge core_clk) begin
    if (we)
      mem[addr] <= wdata;
  end
endmodule : flash_model

// *** tb/test_program_data_memory_map.sv ***
/* bench for the memory map decoder: requests on falling edges.
   assumes the flash model answers from the registered address. */
`timescale 1ns/1ps
module test_program_data_memory_map;
  import memmap_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  flash_size_t flash_size = SIZE_16K;
  mem_req_t prog_req = '0;
  mem_req_t data_req = '0;
  mem_rsp_t prog_rsp;
  mem_rsp_t data_rsp;
  prog_region_t prog_region;
  logic flash_sel;
  logic flash_we;
  logic we_seen;
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] flash_wdata;
  logic [DATA_W-1:0] flash_rdata;
  int failures = 0;
  int cmp_count = 0;
  always #5 core_clk = ~core_clk;
  program_data_memory_map dut (
    .core_clk(core_clk),
    .rst(rst),
    .flash_size(flash_size),
    .prog_req(prog_req),
    .prog_rsp(prog_rsp),
    .prog_region(prog_region),
    .flash_sel(flash_sel),
    .flash_we(flash_we),
    .flash_addr(flash_addr),
    .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata),
    .data_req(data_req),
    .data_rsp(data_rsp)
  );
  flash_model flash (.core_clk(core_clk), .we(flash_we), .addr(flash_addr),
    .wdata(flash_wdata), .rdata(flash_rdata));
  task automatic complete_run;
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp8
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : pat
  task automatic req(input logic d, input logic w, input logic [15:0] a,
      input logic [7:0] wd, output logic [7:0] rd);
    mem_rsp_t rsp;
    @(negedge core_clk);
    if (d)
      data_req = '{1'b1, w, a, wd}; // data space loads, and writes that get no answer
    else
      prog_req = '{1'b1, w, a, wd};
    @(negedge core_clk);
    // write strobe stands only in the cycle after the request edge
    we_seen = flash_we;
    data_req.valid = 1'b0;
    prog_req.valid = 1'b0;
    @(negedge core_clk);
    // answer valid stands one cycle, two edges after the request
    rsp = d ? data_rsp : prog_rsp;
    cmp8({7'h0, rsp.valid}, {7'h0, !w}); // writes get no answer
    rd = rsp.rdata;
  endtask : req
  task automatic sizes_case;
    flash_size_t s [6] = '{SIZE_16K, SIZE_24K, SIZE_32K, SIZE_48K,
      SIZE_64K, flash_size_t'(3'h7)};
    logic [15:0] e [6] = '{16'h3FFF, 16'h5FFF, 16'h7FFF, 16'hBFFF,
      16'hFFFF, 16'h3FFF};
    logic [7:0] rd;
    for (int k = 0; k < 6; k++) begin
      flash_size = s[k];
      req(1'b0, 1'b0, e[k], 8'h00, rd);
      cmp8(rd, pat(e[k]));
      if (e[k] != 16'hFFFF) begin
        req(1'b0, 1'b0, e[k] + 16'h1, 8'h00, rd);
        cmp8(rd, 8'hFF);
      end
    end
  endtask : sizes_case
  task automatic write_case;
    logic [7:0] rd;
    flash_size = SIZE_16K;
    req(1'b0, 1'b1, 16'h4000, 8'h12, rd);
    cmp8({7'h0, we_seen}, 8'h00);
    req(1'b0, 1'b1, 16'h0038, 8'hC3, rd);
    cmp8({7'h0, we_seen}, 8'h01);
    req(1'b0, 1'b0, 16'h0038, 8'h00, rd);
    cmp8(rd, 8'hC3);
    flash_size = SIZE_64K;
    req(1'b0, 1'b0, 16'h4000, 8'h00, rd);
    cmp8(rd, pat(16'h4000));
  endtask : write_case
  task automatic vector_case;
    logic [15:0] a [7] = '{16'h0001, 16'h0002, 16'h0005, 16'h0006,
      16'h0008, 16'h0037, 16'h0038};
    prog_region_t g [7] = '{REG_OPTION, REG_RESET, REG_WDT, REG_TRAP,
      REG_IRQ, REG_IRQ, REG_CODE};
    logic [7:0] rd;
    for (int k = 0; k < 7; k++) begin
      req(1'b0, 1'b0, a[k], 8'h00, rd);
      cmp8({5'h0, prog_region}, {5'h0, g[k]});
    end
  endtask : vector_case
  task automatic data_case;
    logic [159:0] txt = {"PART-001", 96'h0};
    logic [7:0] rd;
    req(1'b1, 1'b1, 16'hFFC0, 8'hAA, rd);
    for (int i = 0; i < 20; i++) begin
      req(1'b1, 1'b0, 16'hFFC0 + 16'(i), 8'h00, rd);
      cmp8(rd, txt[8*(19-i) +: 8]);
    end
    req(1'b1, 1'b0, 16'hFFBF, 8'h00, rd);
    cmp8(rd, 8'h00);
    req(1'b1, 1'b0, 16'hFFD4, 8'h00, rd);
    cmp8(rd, 8'h00);
  endtask : data_case
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    sizes_case();
    write_case();
    vector_case();
    data_case();
    complete_run();
  end
endmodule : test_program_data_memory_map
